// ==== bench/ssi_partner.sv ====
// Purpose: Serial peripheral on the far side while the block is master
// Assumes: Clock edges seen against the system clock
// Notes:   Counts bits only while selected; released data line shows inverse
`timescale 1ns/10ps
`default_nettype none
module ssi_partner (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic       ss_n,
  input  wire logic       idle_lvl,
  input  wire logic       msb_first,
  input  wire logic [7:0] tx,
  output logic            sdi,
  output logic      [7:0] rx
);
  logic [2:0] n_reg;
  logic       sck_reg;
  logic [7:0] rx_reg;
  logic       b;
  // Outgoing bit, inverted when not selected
  assign b   = msb_first ? tx[3'h7 - n_reg] : tx[n_reg];
  assign sdi = ss_n ? ~b : b;
  assign rx  = rx_reg;
  // Leading edge samples, only while selected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      n_reg   <= 3'h0;
      sck_reg <= 1'h1;
      rx_reg  <= 8'h00;
    end else begin
      sck_reg <= sck;
      if (ss_n) begin
        n_reg <= 3'h0;
      end else if (sck == idle_lvl && sck_reg != idle_lvl) begin
        n_reg  <= n_reg + 3'h1;
        rx_reg <= msb_first ? {rx_reg[6:0], sdo} : {sdo, rx_reg[7:1]};
      end
    end
  end
endmodule : ssi_partner
`default_nettype wire

// ==== bench/ssi_serial_bench.sv ====
// Purpose: Self-checking bench of the serial interface block
// Assumes: Bench waits on the ready answer of the register bus
// Notes:   Partner answers in master role, bench drives slave role
`include "ssi_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module ssi_serial_bench;
  logic        clk, resetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sck_o, sck_oe, sdo_o, sdo_oe;
  logic        ss_n_o, ss_n_oe, done, sck_drv, sdi_drv, ss_drv;
  logic        idle, order, sdi_p, sck_w, ss_w;
  logic [7:0]  ptx, rx;
  int          fails, num_checks;
  // Pin levels from enables, select pulled up
  assign sck_w = sck_oe ? sck_o : sck_drv;
  assign ss_w  = ss_n_oe ? ss_n_o : ss_drv;
  ssi_serial i_ssi_serial (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe),
    .SDI_I(sck_oe ? sdi_p : sdi_drv), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SS_N_I(ss_w),
    .SS_N_O(ss_n_o), .SS_N_OE(ss_n_oe), .XFER_DONE(done));
  ssi_partner i_ssi_partner (.clk(clk), .resetn(resetn), .sck(sck_w), .sdo(sdo_o),
    .ss_n(ss_w), .idle_lvl(idle), .msb_first(order), .tx(ptx), .sdi(sdi_p), .rx(rx));
  // Clock
  always #5 clk = ~clk;
  function automatic logic [31:0] c2(input logic e, i, o, s);
    c2 = 32'(e) << `SSI_C2_EDGE | 32'(i) << `SSI_C2_IDLE | 32'(o) << `SSI_C2_ORDER | 32'(s) << `SSI_C2_SELON;
  endfunction : c2
  task automatic chk(input logic [31:0] g, x);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("mismatch %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 100);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    // Let the landed write settle before callers look at pins
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rd
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // Reset values, unused control, unmapped address
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd(`SSI_OFS_DATA, 32'h0);
    rd(`SSI_OFS_CTRL0, 32'h0);
    rd(`SSI_OFS_CTRL1, 32'h0);
    rd(`SSI_OFS_CTRL2, 32'h0);
    chk({sck_oe, sdo_oe, ss_n_oe}, 32'h0);
    apb(1'h0, 12'h010, 32'h0, r, e);
    chk(e, 32'h1);
  endtask : t_reset
  // Master byte exchange, optional colliding write
  task automatic t_master(input logic [2:0] role, input logic [7:0] h, input logic o, i,
                          input logic [7:0] tx, p, input logic col);
    int n;
    wr(`SSI_OFS_CTRL0, 32'h0);
    chk({sck_oe, sdo_oe, ss_n_oe}, 32'h0);
    order <= o;
    idle  <= i;
    ptx   <= p;
    wr(`SSI_OFS_CTRL2, c2(1'h0, i, o, 1'h1));
    wr(`SSI_OFS_CTRL0, 32'(role) << `SSI_C0_ROLE_LO | 32'h1 << `SSI_C0_ON);
    chk({sck_oe, sdo_oe, ss_n_oe, ss_w, sck_o}, {4'he, ~i});
    wr(`SSI_OFS_DATA, 32'(tx));
    // Edges since the data write landed, the two waits below included
    n = 3;
    if (col) begin
      wr(`SSI_OFS_DATA, 32'(~tx));
      n = 7;
    end
    repeat (2) @(posedge clk);
    chk(done, 32'h0);
    while (done !== 1'h1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 16 * h - 1 && n <= 16 * h + 3, 32'h1);
    chk(rx, tx);
    rd(`SSI_OFS_DATA, 32'(p));
    repeat (20) @(posedge clk);
    rd(`SSI_OFS_CTRL2, c2(1'h0, i, o, 1'h1) | 32'(col) << `SSI_C2_WRITE_COLLISION_FLAG | 32'h1);
    wr(`SSI_OFS_CTRL2, c2(1'h0, i, o, 1'h1));
    rd(`SSI_OFS_CTRL2, c2(1'h0, i, o, 1'h1));
  endtask : t_master
  // Select pin off, then slave byte from the bench for one edge select and order
  task automatic t_slave(input logic e, o, input logic [7:0] tx, rxv);
    wr(`SSI_OFS_CTRL2, c2(1'h0, 1'h0, o, 1'h0));
    chk({ss_n_oe, sdo_oe}, 32'h1);
    wr(`SSI_OFS_CTRL0, 32'h5 << `SSI_C0_ROLE_LO | 32'h1 << `SSI_C0_ON);
    wr(`SSI_OFS_CTRL2, c2(e, 1'h0, o, 1'h1));
    // Clock rests on the shift edge side so the first edge samples
    sck_drv <= e;
    wr(`SSI_OFS_DATA, 32'(tx));
    chk({sck_oe, sdo_oe}, 32'h0);
    ss_drv <= 1'h0;
    for (int k = 7; k >= 0; k--) begin
      sdi_drv <= rxv[o ? k : 7 - k];
      repeat (4) @(posedge clk);
      chk({sdo_oe, sdo_o}, {1'h1, tx[o ? k : 7 - k]});
      sck_drv <= ~e;
      repeat (4) @(posedge clk);
      sck_drv <= e;
    end
    repeat (4) @(posedge clk);
    chk(done, 32'h1);
    rd(`SSI_OFS_DATA, 32'(rxv));
    ss_drv <= 1'h1;
  endtask : t_slave
  // Main sequence
  initial begin
    {clk, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sck_drv, sdi_drv, idle, order, ptx, fails, num_checks} = '0;
    ss_drv = 1'h1;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    t_reset;
    t_master(3'h3, `SSI_HALF_3, 1'h1, 1'h0, 8'ha5, 8'h3c, 1'h0);
    t_master(3'h0, `SSI_HALF_0, 1'h0, 1'h1, 8'h81, 8'h5e, 1'h0);
    t_master(3'h2, `SSI_HALF_2, 1'h1, 1'h1, 8'h0f, 8'hc3, 1'h0);
    t_master(3'h4, `SSI_HALF_4, 1'h0, 1'h0, 8'h96, 8'h71, 1'h0);
    t_master(3'h1, `SSI_HALF_1, 1'h1, 1'h0, 8'h6b, 8'h2d, 1'h1);
    t_slave(1'h0, 1'h1, 8'h3c, 8'hd2);
    t_slave(1'h1, 1'h0, 8'ha6, 8'h4b);
    finish_test;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test;
  end
endmodule : ssi_serial_bench
`default_nettype wire

// ==== rtl/ssi_consts.svh ====
// Purpose: Offsets, field positions, reset values and rates of the serial block
// Assumes: APB byte addresses, one 32-bit aligned word per register
// Notes:   Included by the bench and the design
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH
// Register byte addresses
`define SSI_OFS_DATA   12'h000
`define SSI_OFS_CTRL0  12'h004
`define SSI_OFS_CTRL1  12'h008
`define SSI_OFS_CTRL2  12'h00c
// Control zero fields
`define SSI_C0_ROLE_HI 7
`define SSI_C0_ROLE_LO 5
`define SSI_C0_PDOWN   4
`define SSI_C0_ON      1
// Control two fields
`define SSI_C2_EDGE    5
`define SSI_C2_IDLE    4
`define SSI_C2_ORDER   3
`define SSI_C2_SELON   2
`define SSI_C2_WRITE_COLLISION_FLAG    1
`define SSI_C2_DONE    0
// Reset values
`define SSI_RST_DATA   8'h00
`define SSI_RST_CTRL0  8'h00
`define SSI_RST_CTRL2  8'h00
// Role codes at or above this value select slave
`define SSI_SLAVE_CODE 3'h5
// Half serial clock period in system clocks per role code
`define SSI_HALF_0     8'h02
`define SSI_HALF_1     8'h08
`define SSI_HALF_2     8'h20
`define SSI_HALF_3     8'h01
`define SSI_HALF_4     8'h30
`define SSI_LAST_BIT   4'h7
`endif

// ==== rtl/ssi_pkg.sv ====
// Purpose: Types of the serial block
// Assumes: Constants come from the consts header
// Notes:   All block state travels as one packed struct
package ssi_pkg;
  typedef enum logic [1:0] {
    SSI_IDLE  = 2'b00,
    SSI_LEAD  = 2'b01,
    SSI_TRAIL = 2'b10,
    SSI_SRUN  = 2'b11
  } ssi_state_t;

  typedef struct packed {
    ssi_state_t  st;
    logic [7:0]  data;
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl2;
    logic [3:0]  bitcnt;
    logic [7:0]  divcnt;
    logic        sck;
    logic        sdo;
    logic        samp;
    logic        sck_prev;
  } ssi_regs_t;
endpackage : ssi_pkg

// ==== rtl/ssi_serial.sv ====
// Purpose: Serial shift interface, master or slave, full duplex, APB registers
// Assumes: Pin inputs synchronous to CLK; APB slave never waits
// Notes:   Build options are parameters; control two shares storage with slave address
//
// Added by the designer: the placing of the registers and register access over APB.
`include "ssi_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R1: Serial function only with build select, then enable
// R2: Disabled module floats all four pins
// R3: Software initialises controls after enabling
// R4: Role field picks master/slave and master rate
// R5: Slave clock comes from the outside master
// R6: Master data write starts full-duplex shift
// R7: Slave shifts on each received clock edge
// R8: Done flag set at end, low while busy
// R9: Only software clears the done flag; code also clears it at each transfer start
// R10: Data write while busy sets collision flag
// R11: Data write while busy is discarded
// R12: Collision flag sticky, exists by build option
// R13: Select-enable low floats select pin
// R14: Select-enable bit exists by build option
// R15: Bit order high sends MSB first
// R16: Pin drive follows role, select-enable, enable
// R17: Select precedes clock; slave ready before select
// R18: Control zero enable/power/rate, control two rest
// R19: Control two is the slave address storage
// R20: Eight bits per transfer, then done
// R21: Idle level in master, edge select in slave
module ssi_serial #(
  parameter bit SPI_SELECT = 1'b1,
  parameter bit HAS_WRITE_COLLISION_FLAG   = 1'b1,
  parameter bit HAS_SELECT_PIN_ON   = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE,
  input  wire logic        SDI_I,
  output logic             SDO_O,
  output logic             SDO_OE,
  input  wire logic        SS_N_I,
  output logic             SS_N_O,
  output logic             SS_N_OE,
  output logic             XFER_DONE
);

  // Half period of the master clock for a role code
  function automatic logic [7:0] half_period(input logic [2:0] code);
    case (code)
      3'h0:    half_period = `SSI_HALF_0;
      3'h1:    half_period = `SSI_HALF_1;
      3'h2:    half_period = `SSI_HALF_2;
      3'h3:    half_period = `SSI_HALF_3;
      default: half_period = `SSI_HALF_4;
    endcase
  endfunction : half_period

  // Bit that leaves first for the chosen order
  function automatic logic out_bit(input logic [7:0] d, input logic msb);
    out_bit = msb ? d[7] : d[0];
  endfunction : out_bit

  // Shift one bit in from the side opposite the output
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic msb, input logic b);
    shift_in = msb ? {d[6:0], b} : {b, d[7:1]};
  endfunction : shift_in

  ssi_pkg::ssi_regs_t r_reg;
  ssi_pkg::ssi_regs_t r_next;

  logic       on;
  logic       master;
  logic       msb;
  logic       select_pin_on;
  logic       busy;
  logic       wr;
  logic       wr_data;
  logic       wr_c0;
  logic       wr_c2;
  logic       mapped;
  logic       sel_ok;
  logic       edge_rise;
  logic       edge_fall;
  logic       s_sample;
  logic       s_shift;
  logic       half_end;
  logic [7:0] wbyte;

  // Decoded controls
  assign on     = SPI_SELECT & r_reg.ctrl0[`SSI_C0_ON];                          // R1
  assign master = r_reg.ctrl0[`SSI_C0_ROLE_HI:`SSI_C0_ROLE_LO] < `SSI_SLAVE_CODE; // R4
  assign msb    = r_reg.ctrl2[`SSI_C2_ORDER];
  assign select_pin_on   = HAS_SELECT_PIN_ON & r_reg.ctrl2[`SSI_C2_SELON];                         // R14
  assign busy   = (r_reg.st != ssi_pkg::SSI_IDLE);
  assign wbyte  = PWDATA[7:0];

  // APB decode; accesses finish in the access phase
  assign wr      = PSEL & PENABLE & PWRITE;
  assign mapped  = (PADDR == `SSI_OFS_DATA) | (PADDR == `SSI_OFS_CTRL0) |
                   (PADDR == `SSI_OFS_CTRL1) | (PADDR == `SSI_OFS_CTRL2);
  assign wr_data = wr & (PADDR == `SSI_OFS_DATA);
  assign wr_c0   = wr & (PADDR == `SSI_OFS_CTRL0);
  assign wr_c2   = wr & (PADDR == `SSI_OFS_CTRL2);
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // Read mux; control one is unused and reads zero
  always_comb begin
    PRDATA = 32'h0000_0000;
    if (PSEL & ~PWRITE) begin
      case (PADDR)
        `SSI_OFS_DATA:  PRDATA = {24'h00_0000, r_reg.data};
        `SSI_OFS_CTRL0: PRDATA = {24'h00_0000, r_reg.ctrl0};
        `SSI_OFS_CTRL2: PRDATA = {24'h00_0000, r_reg.ctrl2};                    // R19
        default:        PRDATA = 32'h0000_0000;
      endcase
    end
  end

  // Slave edge detection on the received clock
  assign sel_ok    = ~select_pin_on | ~SS_N_I;                                            // R17
  assign edge_rise = SCK_I & ~r_reg.sck_prev;
  assign edge_fall = ~SCK_I & r_reg.sck_prev;
  assign s_sample  = r_reg.ctrl2[`SSI_C2_EDGE] ? edge_fall : edge_rise;          // R21
  assign s_shift   = r_reg.ctrl2[`SSI_C2_EDGE] ? edge_rise : edge_fall;
  assign half_end  = (r_reg.divcnt == 8'(half_period(r_reg.ctrl0[`SSI_C0_ROLE_HI:`SSI_C0_ROLE_LO]) - 8'h01));

  // Next state
  always_comb begin
    r_next          = r_reg;
    r_next.sck_prev = SCK_I;
    // Software writes to controls; a written zero clears a flag, a written one keeps it
    if (wr_c0) begin
      r_next.ctrl0 = wbyte;                                                      // R18
    end
    if (wr_c2) begin
      r_next.ctrl2[7:2] = wbyte[7:2];                                            // R19
      r_next.ctrl2[`SSI_C2_WRITE_COLLISION_FLAG] = r_reg.ctrl2[`SSI_C2_WRITE_COLLISION_FLAG] & wbyte[`SSI_C2_WRITE_COLLISION_FLAG];
      r_next.ctrl2[`SSI_C2_DONE] = r_reg.ctrl2[`SSI_C2_DONE] & wbyte[`SSI_C2_DONE]; // R9
    end
    if (!HAS_SELECT_PIN_ON) begin
      r_next.ctrl2[`SSI_C2_SELON] = 1'b0;                                        // R14
    end
    // Data write: collision when busy, else load
    if (wr_data && on && busy) begin
      r_next.ctrl2[`SSI_C2_WRITE_COLLISION_FLAG] = HAS_WRITE_COLLISION_FLAG;                                     // R10 R12
    end else if (wr_data) begin
      r_next.data = wbyte;                                                       // R11
    end
    case (r_reg.st)
      ssi_pkg::SSI_IDLE: begin
        r_next.sck    = ~r_reg.ctrl2[`SSI_C2_IDLE];                              // R21
        r_next.divcnt = 8'h00;
        r_next.bitcnt = 4'h0;
        r_next.sdo    = out_bit(wr_data ? wbyte : r_reg.data, msb);              // R15
        if (on && master && wr_data) begin
          r_next.st = ssi_pkg::SSI_LEAD;                                         // R6
          r_next.ctrl2[`SSI_C2_DONE] = 1'b0;                                     // R8
        end else if (on && !master && sel_ok && s_sample) begin
          r_next.data   = shift_in(r_reg.data, msb, SDI_I);                      // R7
          r_next.bitcnt = 4'h1;
          r_next.st     = ssi_pkg::SSI_SRUN;
          r_next.ctrl2[`SSI_C2_DONE] = 1'b0;                                     // R8
        end
      end
      ssi_pkg::SSI_LEAD: begin
        r_next.divcnt = r_reg.divcnt + 8'h01;
        if (half_end) begin
          r_next.divcnt = 8'h00;
          r_next.sck    = r_reg.ctrl2[`SSI_C2_IDLE];
          r_next.samp   = SDI_I;
          r_next.st     = ssi_pkg::SSI_TRAIL;
        end
      end
      ssi_pkg::SSI_TRAIL: begin
        r_next.divcnt = r_reg.divcnt + 8'h01;
        if (half_end) begin
          r_next.divcnt = 8'h00;
          r_next.sck    = ~r_reg.ctrl2[`SSI_C2_IDLE];
          r_next.data   = shift_in(r_reg.data, msb, r_reg.samp);                 // R6
          r_next.sdo    = out_bit(shift_in(r_reg.data, msb, r_reg.samp), msb);   // R15
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
          if (r_reg.bitcnt == `SSI_LAST_BIT) begin
            r_next.st = ssi_pkg::SSI_IDLE;
            r_next.ctrl2[`SSI_C2_DONE] = 1'b1;                                   // R20
          end else begin
            r_next.st = ssi_pkg::SSI_LEAD;
          end
        end
      end
      ssi_pkg::SSI_SRUN: begin
        if (!sel_ok) begin
          r_next.st = ssi_pkg::SSI_IDLE;                                         // R17
        end else if (s_shift) begin
          r_next.sdo = out_bit(r_reg.data, msb);                                 // R7
        end else if (s_sample) begin
          r_next.data   = shift_in(r_reg.data, msb, SDI_I);
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
          if (r_reg.bitcnt == `SSI_LAST_BIT) begin
            r_next.st = ssi_pkg::SSI_IDLE;
            r_next.ctrl2[`SSI_C2_DONE] = 1'b1;                                   // R20
          end
        end
      end
      default: begin
        r_next.st = ssi_pkg::SSI_IDLE;
      end
    endcase
    // Disabled or role change aborts any transfer
    if (!on || (master != (r_reg.st != ssi_pkg::SSI_SRUN) && busy)) begin
      r_next.st = ssi_pkg::SSI_IDLE;                                             // R2
    end
  end

  // State register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r_reg.st       <= ssi_pkg::SSI_IDLE;
      r_reg.data     <= `SSI_RST_DATA;
      r_reg.ctrl0    <= `SSI_RST_CTRL0;
      r_reg.ctrl2    <= `SSI_RST_CTRL2;
      r_reg.bitcnt   <= 4'h0;
      r_reg.divcnt   <= 8'h00;
      r_reg.sck      <= 1'b1;
      r_reg.sdo      <= 1'b0;
      r_reg.samp     <= 1'b0;
      r_reg.sck_prev <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Pin drive by role, select-enable and enable
  assign SCK_O     = r_reg.sck;
  assign SCK_OE    = on & master;                                                // R16 R5
  assign SDO_O     = r_reg.sdo;
  assign SDO_OE    = on & (master | sel_ok);                                     // R16
  assign SS_N_O    = 1'b0;
  assign SS_N_OE   = on & master & select_pin_on;                                         // R13 R16
  assign XFER_DONE = r_reg.ctrl2[`SSI_C2_DONE];

  // Assertions
  logic [2:0] role;
  assign role = r_reg.ctrl0[`SSI_C0_ROLE_HI:`SSI_C0_ROLE_LO];

  sequence s_mstart;
    on && master && !busy && wr_data && role == 3'h3;
  endsequence

  sequence s_eight_bits;
    (busy && !XFER_DONE)[*8] ##[1:40] XFER_DONE;
  endsequence

  property p_start;
    @(posedge CLK) disable iff (!RESETN)
      on && master && !busy && wr_data |=> r_reg.st == ssi_pkg::SSI_LEAD;
  endproperty
  a_start: assert property (p_start) else $error("master write did not start shift"); // R6

  property p_eight;
    @(posedge CLK) disable iff (!RESETN)
      s_mstart |=> s_eight_bits;
  endproperty
  a_eight: assert property (p_eight) else $error("transfer length wrong"); // R20

  property p_collide;
    @(posedge CLK) disable iff (!RESETN)
      wr_data && on && busy && HAS_WRITE_COLLISION_FLAG |=> r_reg.ctrl2[`SSI_C2_WRITE_COLLISION_FLAG];
  endproperty
  a_collide: assert property (p_collide) else $error("collision not flagged"); // R10

  property p_discard;
    @(posedge CLK) disable iff (!RESETN)
      wr_data && on && r_reg.st == ssi_pkg::SSI_LEAD && !half_end |=> $stable(r_reg.data);
  endproperty
  a_discard: assert property (p_discard) else $error("busy write changed data"); // R11

  property p_float;
    @(posedge CLK) disable iff (!RESETN)
      !on |-> !SCK_OE && !SDO_OE && !SS_N_OE;
  endproperty
  a_float: assert property (p_float) else $error("pin driven while disabled"); // R2

  property p_sticky;
    @(posedge CLK) disable iff (!RESETN)
      XFER_DONE && !wr_c2 && !wr_data |=> XFER_DONE;
  endproperty
  a_sticky: assert property (p_sticky) else $error("done flag cleared by hardware"); // R9

  property p_slave_sdo;
    @(posedge CLK) disable iff (!RESETN)
      on && !master && select_pin_on && SS_N_I |-> !SDO_OE;
  endproperty
  a_slave_sdo: assert property (p_slave_sdo) else $error("deselected slave drives data"); // R16

  property p_select_pin_on;
    @(posedge CLK) disable iff (!RESETN)
      !select_pin_on |-> !SS_N_OE;
  endproperty
  a_select_pin_on: assert property (p_select_pin_on) else $error("select pin driven while off"); // R13

  property p_order;
    @(posedge CLK) disable iff (!RESETN)
      on && master && !busy && wr_data && msb |=> SDO_O == $past(PWDATA[7]);
  endproperty
  a_order: assert property (p_order) else $error("first bit not MSB"); // R15

  property p_idle_sck;
    @(posedge CLK) disable iff (!RESETN)
      on && master && !busy ##1 !busy |-> SCK_O == ~$past(r_reg.ctrl2[`SSI_C2_IDLE]);
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("idle clock level wrong"); // R21

endmodule : ssi_serial
`default_nettype wire
